/* File: dither_timestamp_link_ctrl_bench.sv */
`timescale 1ns/100ps
// ----------
// Bench
// ----------
module dither_timestamp_link_ctrl_bench import dtl_pkg::*; ();
	localparam int LAT = 4;
	localparam int MF_PER = 32;
	logic              clock = 0, rst_n = 0, reg_write = 0, reg_read = 0;
	logic              cal_enable = 1, sysref = 0, sample_narrow = 0;
	logic              sk = 0, run = 0, dn, cn;
	logic              link_enable, link_reset_n, link_clock_enable;
	logic              serializer_power_down;
	logic              m_r = 0, le = 0, mb = 0, pv = 0, mfb;
	logic [3:0]        acb;
	int                ms = 0, mc = 0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, link_mode_select, d;
	logic [DATA_W-1:0] m_d = 8'h01, m_m = 8'h00, m_e = 8'h01, m_o = 8'h02;
	logic [255:0]      mode_allowed;
	logic [7:0]        mfc;
	logic [13:0]       q[$];
	logic [ADDR_W-1:0] ad[6] = '{OFS_DITHER, OFS_MARKER, OFS_LINK_EN,
		OFS_LINK_MODE, 12'h123, OFS_STATUS};
	dtl_sample_t       sample_in = '0, sample_out, ds, ce;
	dtl_dither_t       dither_ctrl;
	int                n_errors = 0, num_checks = 0;

	always #2 clock = ~clock;

	dtl_ctrl uut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .mode_allowed(mode_allowed),
		.cal_enable(cal_enable), .sysref(sysref), .sample_in(sample_in),
		.sample_narrow(sample_narrow), .sample_out(sample_out),
		.dither_ctrl(dither_ctrl), .link_enable(link_enable),
		.link_mode_select(link_mode_select), .link_reset_n(link_reset_n),
		.serializer_power_down(serializer_power_down),
		.link_clock_enable(link_clock_enable),
		.multiframe_clock_counter(mfc), .multiframe_boundary(mfb),
		.advertised_control_bits(acb));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function logic [7:0] mr(input logic [11:0] a);
		case (a)
			OFS_DITHER: return m_d;
			OFS_MARKER: return m_m;
			OFS_LINK_EN: return m_e;
			OFS_LINK_MODE: return m_o;
			OFS_STATUS: return {6'h00, m_r, m_e[0]};
			default: return 8'h00;
		endcase
	endfunction

	task wr(input logic [11:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		case (a)
			OFS_DITHER: m_d = v;
			OFS_MARKER: m_m = v;
			OFS_LINK_EN: m_e = v;
			OFS_LINK_MODE: begin
				if (mode_allowed[v]) m_o = v;
				else m_r = 1'b1;
			end
			OFS_STATUS: if (v[1]) m_r = 1'b0;
			default: ;
		endcase
	endtask

	task rd(input logic [11:0] a);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(negedge clock);
		chk(reg_rdata, mr(a));
		@(posedge clock);
	endtask

	task stop_test;
		$display("errors=%0d checks=%0d", n_errors, num_checks);
		if (n_errors == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Raw samples are queued; the marker merge is applied at compare time.
	always @(posedge clock) if (run) begin
		ds = 13'($urandom);
		dn = 1'($urandom);
		if (dn) ds.data[3:0] = 4'h0;
		sample_in <= ds;
		sample_narrow <= dn;
		sysref <= ($urandom % 8) == 0;
		q.push_back({dn, ds});
	end

	always @(negedge clock) if (q.size() > LAT + 1) begin
		{cn, ce} = q.pop_front();
		if (m_m[0]) ce.data[cn ? 4 : 0] = ce.marker;
		if (!sk) chk(sample_out, ce);
	end

	// Link and counter model: each falling edge predicts what the next
	// rising edge leaves on the pins, and checks it one cycle later.
	always @(negedge clock) begin
		if (pv) begin
			chk({link_enable, link_reset_n}, {le, ms == 2});
			chk({serializer_power_down, link_clock_enable},
				{ms == 0, ms != 0});
			chk(mfc, mc);
			chk(mfb, mb);
			chk(acb, 4'h0);
		end
		if (!rst_n) begin
			le = 1'b0;
			ms = 0;
		end else begin
			le = m_e[0];
			ms = !m_e[0] ? 0 : (ms == 0 ? 1 : 2);
		end
		mc = (ms != 2 || sysref || mc == MF_PER - 1) ? 0 : mc + 1;
		mb = ms == 2 && mc == 0;
		pv = 1'b1;
	end

	initial begin
		#20000;
		n_errors++;
		stop_test;
	end

	initial begin
		void'($urandom(16428));
		mode_allowed = {8{$urandom}};
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		run <= 1'b1;
		foreach (ad[i]) rd(ad[i]);
		repeat (8) begin
			d = 8'($urandom);
			wr(OFS_DITHER, d);
			@(posedge clock);
			@(negedge clock);
			chk(dither_ctrl, {d[0], d[1], d[2]});
			@(posedge clock);
			rd(OFS_DITHER);
		end
		// The merge switches mid-pipeline, so compares pause meanwhile.
		sk = 1'b1;
		// The paired sync receiver enable sits outside this block.
		wr(OFS_MARKER, {d[7:1], 1'b1});
		repeat (8) @(posedge clock);
		sk = 1'b0;
		repeat (40) @(posedge clock);
		rd(OFS_MARKER);
		wr(OFS_LINK_EN, 8'h00);
		@(posedge clock);
		@(negedge clock);
		chk({link_enable, link_reset_n, serializer_power_down,
			link_clock_enable}, 4'h2);
		@(posedge clock);
		cal_enable <= 1'b0;
		repeat (8) begin
			d = 8'($urandom);
			wr(OFS_LINK_MODE, d);
			rd(OFS_LINK_MODE);
			@(negedge clock);
			chk(link_mode_select, m_o);
			chk(mfc, 8'h00);
			@(posedge clock);
			rd(OFS_STATUS);
		end
		wr(OFS_STATUS, 8'h02);
		rd(OFS_STATUS);
		cal_enable <= 1'b1;
		@(posedge clock);
		wr(OFS_LINK_EN, 8'h01);
		@(posedge clock);
		@(negedge clock);
		chk({link_enable, link_reset_n, serializer_power_down,
			link_clock_enable}, 4'h9);
		@(negedge clock);
		chk({link_enable, link_reset_n, serializer_power_down,
			link_clock_enable}, 4'hd);
		@(posedge clock);
		rd(OFS_LINK_EN);
		rd(OFS_STATUS);
		stop_test;
	end
endmodule

/* File: dtl_ctrl.sv */
`timescale 1ns/100ps
module dtl_ctrl import dtl_pkg::*; #(
	parameter int LATENCY   = 4,
	parameter int NUM_MODES = 256,
	parameter int MF_PERIOD = 32,
	parameter int MF_W      = 8
) (
	input  wire logic                   clock,
	input  wire logic                   rst_n,
	input  wire logic [ADDR_W-1:0]      reg_addr,
	input  wire logic [DATA_W-1:0]      reg_wdata,
	input  wire logic                   reg_write,
	input  wire logic                   reg_read,
	output logic [DATA_W-1:0]           reg_rdata,
	input  wire logic [NUM_MODES-1:0]   mode_allowed,
	input  wire logic                   cal_enable,
	input  wire logic                   sysref,
	input  wire dtl_sample_t            sample_in,
	input  wire logic                   sample_narrow,
	output dtl_sample_t                 sample_out,
	output dtl_dither_t                 dither_ctrl,
	output logic                        link_enable,
	output logic [DATA_W-1:0]           link_mode_select,
	output logic                        link_reset_n,
	output logic                        serializer_power_down,
	output logic                        link_clock_enable,
	output logic [MF_W-1:0]             multiframe_clock_counter,
	output logic                        multiframe_boundary,
	output logic [3:0]                  advertised_control_bits
);

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	if (LATENCY < 1) begin : g_bad_latency
		$error("LATENCY must be at least one stage.");
	end
	if (NUM_MODES < 1 || NUM_MODES > 256) begin : g_bad_modes
		$error("NUM_MODES must lie between 1 and 256.");
	end
	if (MF_PERIOD < 2 || MF_PERIOD > (1 << MF_W)) begin : g_bad_mf
		$error("MF_PERIOD must fit the counter width.");
	end

	localparam logic [MF_W-1:0] MF_LAST = MF_W'(MF_PERIOD - 1);
	localparam logic [MF_W-1:0] MF_ZERO = '0;

	// ------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------
	logic [DATA_W-1:0] dither_q;
	logic [DATA_W-1:0] marker_q;
	logic [DATA_W-1:0] link_en_q;
	logic [DATA_W-1:0] link_mode_q;
	logic              mode_rej_q;
	logic              mode_rej_d;
	logic              wr_dither;
	logic              wr_marker;
	logic              wr_link_en;
	logic              wr_link_mode;
	logic              wr_status;
	logic              mode_ok;

	assign wr_dither = reg_write && (reg_addr == OFS_DITHER);
	assign wr_marker = reg_write && (reg_addr == OFS_MARKER);
	assign wr_link_en = reg_write && (reg_addr == OFS_LINK_EN);
	assign wr_link_mode = reg_write && (reg_addr == OFS_LINK_MODE);
	assign wr_status = reg_write && (reg_addr == OFS_STATUS);

	// Modes beyond the table are refused as well as locked ones.
	always_comb begin
		mode_ok = 1'b0;
		if (32'(reg_wdata) < NUM_MODES) begin
			mode_ok = mode_allowed[reg_wdata];
		end
	end

	// Reserved bits are stored as written and drive nothing.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			dither_q <= RST_DITHER;
		end else if (wr_dither) begin
			dither_q <= reg_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			marker_q <= RST_MARKER;
		end else if (wr_marker) begin
			marker_q <= reg_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			link_en_q <= RST_LINK_EN;
		end else if (wr_link_en) begin
			link_en_q <= reg_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			link_mode_q <= RST_LINK_MODE;
		end else if (wr_link_mode && mode_ok) begin
			link_mode_q <= reg_wdata;
		end
	end

	// A refusal in the same cycle as a clear keeps the flag set.
	always_comb begin
		mode_rej_d = mode_rej_q;
		if (wr_status && reg_wdata[BIT_ST_MODE_REJ]) begin
			mode_rej_d = 1'b0;
		end
		if (wr_link_mode && !mode_ok) begin
			mode_rej_d = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mode_rej_q <= 1'b0;
		end else begin
			mode_rej_q <= mode_rej_d;
		end
	end

	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------
	logic [DATA_W-1:0] rdata_d;
	logic              link_on;

	// The status word is local to this block; only its two low bits mean
	// anything and the rest read as zero.

	always_comb begin
		rdata_d = '0;
		case (reg_addr)
			OFS_DITHER: begin
				rdata_d = dither_q;
			end
			OFS_MARKER: begin
				rdata_d = marker_q;
			end
			OFS_LINK_EN: begin
				rdata_d = link_en_q;
			end
			OFS_LINK_MODE: begin
				rdata_d = link_mode_q;
			end
			OFS_STATUS: begin
				rdata_d[BIT_ST_LINK_ON] = link_on;
				rdata_d[BIT_ST_MODE_REJ] = mode_rej_q;
			end
			default: begin
				rdata_d = '0;
			end
		endcase
	end

	// Read data is held only for the cycle after the strobe.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_read) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= '0;
		end
	end

	// ------------------------------------------------------------------
	// Dither control outputs
	// ------------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			dither_ctrl.dither_enable <= RST_DITHER[BIT_DITHER_EN];
			dither_ctrl.dither_amplitude_select <=
				RST_DITHER[BIT_DITHER_AMP];
			dither_ctrl.rounding_error_select <=
				RST_DITHER[BIT_ROUND_ERR];
		end else begin
			dither_ctrl.dither_enable <= dither_q[BIT_DITHER_EN];
			dither_ctrl.dither_amplitude_select <=
				dither_q[BIT_DITHER_AMP];
			dither_ctrl.rounding_error_select <=
				dither_q[BIT_ROUND_ERR];
		end
	end

	// ------------------------------------------------------------------
	// Link enable sequencing
	// ------------------------------------------------------------------
	dtl_link_state_t state_q;
	dtl_link_state_t state_d;
	logic            en_bit;

	// Calibration ordering is left to software: cal_enable is brought in
	// for visibility only, and no write is ever refused because of it.

	assign en_bit = link_en_q[BIT_LINK_EN];
	assign link_on = (state_q == DTL_LINK_RUN);

	// Clocks come back one cycle before reset releases so the link logic
	// sees running clocks when it leaves reset.
	always_comb begin
		state_d = state_q;
		case (state_q)
			DTL_LINK_OFF: begin
				if (en_bit) begin
					state_d = DTL_LINK_START;
				end
			end
			DTL_LINK_START: begin
				state_d = en_bit ? DTL_LINK_RUN : DTL_LINK_OFF;
			end
			DTL_LINK_RUN: begin
				if (!en_bit) begin
					state_d = DTL_LINK_OFF;
				end
			end
			default: begin
				state_d = DTL_LINK_OFF;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_q <= DTL_LINK_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			link_enable <= 1'b0;
			link_reset_n <= 1'b0;
			serializer_power_down <= 1'b1;
			link_clock_enable <= 1'b0;
		end else begin
			link_enable <= en_bit;
			link_reset_n <= (state_d == DTL_LINK_RUN);
			serializer_power_down <= (state_d == DTL_LINK_OFF);
			link_clock_enable <= (state_d != DTL_LINK_OFF);
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			link_mode_select <= RST_LINK_MODE;
		end else begin
			link_mode_select <= link_mode_q;
		end
	end

	// ------------------------------------------------------------------
	// Multiframe clock counter
	// ------------------------------------------------------------------
	logic [MF_W-1:0] mf_d;

	// The counter leaves reset together with the link, so the first running
	// cycle already reads one; fire SYSREF after the enable for a boundary.

	always_comb begin
		mf_d = multiframe_clock_counter + MF_W'(1);
		if (multiframe_clock_counter == MF_LAST) begin
			mf_d = MF_ZERO;
		end
		if (sysref) begin
			mf_d = MF_ZERO;
		end
		if (state_d != DTL_LINK_RUN) begin
			mf_d = MF_ZERO;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			multiframe_clock_counter <= MF_ZERO;
			multiframe_boundary <= 1'b0;
		end else begin
			multiframe_clock_counter <= mf_d;
			multiframe_boundary <= (state_d == DTL_LINK_RUN) &&
				(mf_d == MF_ZERO);
		end
	end

	// ------------------------------------------------------------------
	// Sample path with timestamp marker
	// ------------------------------------------------------------------
	// Marker and data share one pipeline so they can never drift apart.
	dtl_sample_t pipe_q [LATENCY];
	dtl_sample_t merged;
	logic        narrow_q [LATENCY];

	for (genvar i = 0; i < LATENCY; i++) begin : g_pipe
		always_ff @(posedge clock) begin
			if (!rst_n) begin
				pipe_q[i] <= '0;
				narrow_q[i] <= 1'b0;
			end else if (i == 0) begin
				pipe_q[i] <= sample_in;
				narrow_q[i] <= sample_narrow;
			end else begin
				pipe_q[i] <= pipe_q[(i == 0) ? 0 : i-1];
				narrow_q[i] <= narrow_q[(i == 0) ? 0 : i-1];
			end
		end
	end

	always_comb begin
		merged = pipe_q[LATENCY-1];
		if (marker_q[BIT_MARKER_EN]) begin
			if (narrow_q[LATENCY-1]) begin
				merged.data[NARROW_LSB] = merged.marker;
			end else begin
				merged.data[WIDE_LSB] = merged.marker;
			end
		end
	end

	// The final stage counts toward the latency seen at the pins.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sample_out <= '0;
		end else begin
			sample_out <= merged;
		end
	end

	// The marker is never announced in the lane alignment sequence.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			advertised_control_bits <= ADVERTISED_CS;
		end else begin
			advertised_control_bits <= ADVERTISED_CS;
		end
	end

endmodule

/* File: dtl_ctrl_monitor.sv */
`timescale 1ns/100ps
// ----------
// Port checks
// ----------
module dtl_ctrl_monitor import dtl_pkg::*; #(
	parameter int LATENCY   = 4,
	parameter int NUM_MODES = 256,
	parameter int MF_W      = 8
) (
	input wire logic                 clock,
	input wire logic                 rst_n,
	input wire logic [ADDR_W-1:0]    reg_addr,
	input wire logic [DATA_W-1:0]    reg_wdata,
	input wire logic                 reg_write,
	input wire logic                 reg_read,
	input wire logic [DATA_W-1:0]    reg_rdata,
	input wire logic [NUM_MODES-1:0] mode_allowed,
	input wire logic                 sysref,
	input wire dtl_sample_t          sample_in,
	input wire dtl_sample_t          sample_out,
	input wire dtl_dither_t          dither_ctrl,
	input wire logic                 link_enable,
	input wire logic [DATA_W-1:0]    link_mode_select,
	input wire logic                 link_reset_n,
	input wire logic                 serializer_power_down,
	input wire logic                 link_clock_enable,
	input wire logic [MF_W-1:0]      multiframe_clock_counter,
	input wire logic [3:0]           advertised_control_bits
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_wr(logic [ADDR_W-1:0] a);
		reg_write && reg_addr == a;
	endsequence
	a_rdata_idle:
		assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	a_dither_follow:
		assert property (s_wr(OFS_DITHER) |-> ##2 dither_ctrl ==
			{$past(reg_wdata[0], 2), $past(reg_wdata[1], 2),
			$past(reg_wdata[2], 2)})
		else $error("dither outputs do not follow register");
	a_link_off:
		assert property (s_wr(OFS_LINK_EN) ##0 !reg_wdata[0] |-> ##2
			!link_enable && !link_clock_enable && serializer_power_down
			&& !link_reset_n)
		else $error("link not shut down");
	a_link_on:
		assert property (s_wr(OFS_LINK_EN) ##0 reg_wdata[0] |-> ##2
			link_enable && link_clock_enable && !serializer_power_down
			##1 link_reset_n)
		else $error("link not started");
	a_count_held:
		assert property (!link_reset_n |-> multiframe_clock_counter == '0)
		else $error("counter runs while link off");
	a_sysref_zero:
		assert property (link_reset_n && sysref |=>
			multiframe_clock_counter == '0)
		else $error("counter not realigned");
	a_no_cs:
		assert property (advertised_control_bits == 4'h0)
		else $error("control bits advertised");
	a_mode_take:
		assert property (s_wr(OFS_LINK_MODE) ##0 mode_allowed[reg_wdata]
			|-> ##2 link_mode_select == $past(reg_wdata, 2))
		else $error("allowed mode not taken");
	a_mode_refuse:
		assert property (s_wr(OFS_LINK_MODE) ##0 !mode_allowed[reg_wdata]
			##1 !reg_write |-> ##1 $stable(link_mode_select))
		else $error("locked mode taken");
	a_marker_lat:
		assert property (sample_out.marker ==
			$past(sample_in.marker, LATENCY + 1))
		else $error("marker latency wrong");
endmodule
bind dtl_ctrl dtl_ctrl_monitor #(.LATENCY(LATENCY), .NUM_MODES(NUM_MODES),
	.MF_W(MF_W)) u_mon (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .mode_allowed(mode_allowed), .sysref(sysref),
	.sample_in(sample_in), .sample_out(sample_out),
	.dither_ctrl(dither_ctrl), .link_enable(link_enable),
	.link_mode_select(link_mode_select), .link_reset_n(link_reset_n),
	.serializer_power_down(serializer_power_down),
	.link_clock_enable(link_clock_enable),
	.multiframe_clock_counter(multiframe_clock_counter),
	.advertised_control_bits(advertised_control_bits));

/* File: dtl_pkg.sv */
package dtl_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int SAMPLE_W = 12;

	localparam logic [ADDR_W-1:0] OFS_DITHER = 12'h09d;
	localparam logic [ADDR_W-1:0] OFS_MARKER = 12'h160;
	localparam logic [ADDR_W-1:0] OFS_LINK_EN = 12'h200;
	localparam logic [ADDR_W-1:0] OFS_LINK_MODE = 12'h201;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h3f0;

	localparam logic [DATA_W-1:0] RST_DITHER = 8'h01;
	localparam logic [DATA_W-1:0] RST_MARKER = 8'h00;
	localparam logic [DATA_W-1:0] RST_LINK_EN = 8'h01;
	localparam logic [DATA_W-1:0] RST_LINK_MODE = 8'h02;

	localparam int BIT_DITHER_EN = 0;
	localparam int BIT_DITHER_AMP = 1;
	localparam int BIT_ROUND_ERR = 2;
	localparam int BIT_MARKER_EN = 0;
	localparam int BIT_LINK_EN = 0;
	localparam int BIT_ST_LINK_ON = 0;
	localparam int BIT_ST_MODE_REJ = 1;

	// Narrow samples sit in the top byte of the sample word.
	localparam int NARROW_LSB = 4;
	localparam int WIDE_LSB = 0;

	localparam logic [3:0] ADVERTISED_CS = 4'h0;

	typedef struct packed {
		logic                marker;
		logic [SAMPLE_W-1:0] data;
	} dtl_sample_t;

	typedef struct packed {
		logic dither_enable;
		logic dither_amplitude_select;
		logic rounding_error_select;
	} dtl_dither_t;

	typedef enum logic [1:0] {
		DTL_LINK_OFF   = 2'b00,
		DTL_LINK_START = 2'b01,
		DTL_LINK_RUN   = 2'b10
	} dtl_link_state_t;

endpackage
